/* File: src/usb_mbox_pkg.sv */
`default_nettype none

package usb_mbox_pkg;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [7:0] data8_t;
  typedef logic [2:0] mbox_idx_t;
  typedef logic [6:0] fifo_count_t;
  typedef logic [5:0] fifo_ptr_t;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int ADR_W = 18;
  localparam int DAT_W = 32;
  localparam int SEL_W = 4;

  // ----------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_INT_EN0    = 16'h4002;
  localparam logic [15:0] IDX_INT_STAT0  = 16'h4004;
  localparam logic [15:0] IDX_INT_EN1    = 16'h4006;
  localparam logic [15:0] IDX_INT_STAT1  = 16'h4008;
  localparam logic [15:0] IDX_EP1_PTR    = 16'h4010;
  localparam logic [15:0] IDX_EP1_DATA   = 16'h4012;
  localparam logic [15:0] IDX_EP2_PTR    = 16'h4018;
  localparam logic [15:0] IDX_EP2_DATA   = 16'h401a;
  localparam logic [15:0] IDX_EP2_POLL   = 16'h401c;
  localparam logic [15:0] IDX_RXF_DATA   = 16'h4020;
  localparam logic [15:0] IDX_RXF_COUNT  = 16'h4022;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ST0_SUMMARY = 0;
  localparam int ST0_EP1     = 1;
  localparam int ST0_EP2     = 2;
  localparam int ST0_EP3     = 3;
  localparam int ST1_RX_AF   = 0;
  localparam int ST1_TX_AE   = 1;

  // ----------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------
  localparam data8_t      POLL_RESET  = 8'hff;
  localparam data8_t      DATA_RESET  = 8'h00;
  localparam mbox_idx_t   PTR_RESET   = 3'h0;
  localparam mbox_idx_t   MBOX_LAST   = 3'h7;
  localparam int          MBOX_DEPTH  = 8;
  localparam int          FIFO_DEPTH  = 64;
  localparam fifo_count_t COUNT_RESET = 7'h00;
  localparam fifo_count_t COUNT_FULL  = 7'h40;

endpackage

`default_nettype wire

/* File: src/mbox_if.sv */
`default_nettype none

interface mbox_if;
  import usb_mbox_pkg::*;

  // CPU side
  logic      cpu_access;
  logic      cpu_we;
  data8_t    cpu_wdata;
  logic      ptr_we;
  mbox_idx_t ptr_wdata;
  data8_t    cpu_rdata;
  mbox_idx_t ptr;
  // USB side
  logic      usb_we;
  mbox_idx_t usb_idx;
  data8_t    usb_wdata;
  data8_t    usb_rdata;

  modport ctrl  (output cpu_access, cpu_we, cpu_wdata, ptr_we, ptr_wdata,
                 usb_we, usb_idx, usb_wdata,
                 input  cpu_rdata, ptr, usb_rdata);
  modport store (input  cpu_access, cpu_we, cpu_wdata, ptr_we, ptr_wdata,
                 usb_we, usb_idx, usb_wdata,
                 output cpu_rdata, ptr, usb_rdata);
endinterface

`default_nettype wire

/* File: src/mailbox8.sv */
`default_nettype none

module mailbox8
(
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Mailbox access
  mbox_if.store     bus
);
  import usb_mbox_pkg::*;

  data8_t    mem [MBOX_DEPTH];
  mbox_idx_t ptr;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // USB write wins over a CPU write in the same cycle
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < MBOX_DEPTH; i++)
        mem[i] <= DATA_RESET;
    end
    else if (bus.usb_we)
      mem[bus.usb_idx] <= bus.usb_wdata;
    else if (bus.cpu_access && bus.cpu_we)
      mem[ptr] <= bus.cpu_wdata;
  end

  // ----------------------------------------------------------------
  // Pointer
  // ----------------------------------------------------------------
  // Steps after each CPU access and wraps after the last byte
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ptr <= PTR_RESET;
    else if (bus.ptr_we)
      ptr <= bus.ptr_wdata;
    else if (bus.cpu_access)
      ptr <= (ptr == MBOX_LAST) ? PTR_RESET : 3'(ptr + 3'h1);
  end

  // Read paths
  assign bus.cpu_rdata = mem[ptr];
  assign bus.usb_rdata = mem[bus.usb_idx];
  assign bus.ptr       = ptr;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_ptr_wrap_zero: assert property (
    @(posedge clk_sys) disable iff (rst)
    bus.cpu_access && !bus.ptr_we && ptr == MBOX_LAST |=> ptr == PTR_RESET)
    else $error("mailbox pointer did not wrap to zero");

endmodule

`default_nettype wire

/* File: src/usb_endpoint_mailbox_fifo.sv */
// Local design decision: the Wishbone slave port.
`default_nettype none

// How it works
// - Enabled receive almost-full status raises interrupt
// - Transmit almost-empty set at threshold byte sent
// - Receive almost-full set on a byte received at threshold count
// - Endpoint 1 pointer selects mailbox byte read
// - Endpoint 1 pointer steps per read, wraps
// - USB loads receive mailbox; CPU reads it
// - Endpoint 1 end of transfer can interrupt CPU
// - Endpoint 2 pointer steps per access, wraps
// - CPU fills transmit mailbox; USB reads it
// - Polling interval register resets to ff
// - CPU pops receive FIFO through data port
// - Count register reports 0 to 64 entries
// - Endpoint 1 end of transfer sets status bit one
// - Endpoint 3 refuses packets while flagged
// - Summary bit shows any upper status set

module usb_endpoint_mailbox_fifo
(
  // Clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  // Wishbone slave
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  input  wire logic                          wb_we_i,
  input  wire logic [usb_mbox_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [usb_mbox_pkg::SEL_W-1:0] wb_sel_i,
  input  wire logic [usb_mbox_pkg::DAT_W-1:0] wb_dat_i,
  output logic      [usb_mbox_pkg::DAT_W-1:0] wb_dat_o,
  output logic                               wb_ack_o,
  // Interrupt
  output logic                               irq,
  // Endpoint 1 receive mailbox, USB side
  input  wire logic                          usb_ep1_we,
  input  wire usb_mbox_pkg::mbox_idx_t       usb_ep1_idx,
  input  wire usb_mbox_pkg::data8_t          usb_ep1_data,
  input  wire logic                          usb_ep1_done,
  // Endpoint 2 transmit mailbox, USB side
  input  wire usb_mbox_pkg::mbox_idx_t       usb_ep2_idx,
  output usb_mbox_pkg::data8_t               usb_ep2_data,
  input  wire logic                          usb_ep2_done,
  output usb_mbox_pkg::data8_t               ep2_poll_interval,
  // Endpoint 3 receive FIFO, USB side
  input  wire logic                          usb_ep3_valid,
  input  wire usb_mbox_pkg::data8_t          usb_ep3_data,
  output logic                               usb_ep3_ready,
  input  wire logic                          usb_ep3_done,
  // Transmit FIFO progress and thresholds
  input  wire usb_mbox_pkg::fifo_count_t     tx_count,
  input  wire logic                          tx_byte_sent,
  input  wire usb_mbox_pkg::fifo_count_t     tx_threshold,
  input  wire usb_mbox_pkg::fifo_count_t     rx_threshold
);
  import usb_mbox_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic        take;
  logic        rd;
  logic        wr;
  logic [15:0] word;
  logic        hit_ep1_data;
  logic        hit_ep2_data;
  logic        hit_rxf_data;
  logic [31:0] next_rdata;

  logic [3:1]  stat0;
  logic [3:1]  en0;
  logic [1:0]  stat1;
  logic [1:0]  en1;
  logic [3:1]  set0;
  logic [3:1]  clr0;
  logic [1:0]  set1;
  logic [1:0]  clr1;

  data8_t      poll;

  data8_t      fifo_mem [FIFO_DEPTH];
  fifo_ptr_t   wr_ptr;
  fifo_ptr_t   rd_ptr;
  fifo_count_t rx_count;
  logic        rx_push;
  logic        rx_pop;
  logic        fifo_full;
  logic        fifo_empty;

  mbox_if ep1_bus ();
  mbox_if ep2_bus ();

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // A request is taken in the cycle before ack, ack lasts one cycle
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign rd   = take && !wb_we_i;
  assign wr   = take && wb_we_i && wb_sel_i[0];
  assign word = wb_adr_i[17:2];

  // Data port decodes, their reads and endpoint 2 writes have side effects
  assign hit_ep1_data = (word == IDX_EP1_DATA);
  assign hit_ep2_data = (word == IDX_EP2_DATA);
  assign hit_rxf_data = (word == IDX_RXF_DATA);

  // Acknowledge every access, mapped or not
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= take;
  end

  // Read mux, unmapped and reserved bits read as zero
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (word)
      IDX_INT_EN0:   next_rdata[3:1] = en0;
      IDX_INT_STAT0:
      begin
        next_rdata[3:1]         = stat0;
        next_rdata[ST0_SUMMARY] = |stat1;
      end
      IDX_INT_EN1:   next_rdata[1:0] = en1;
      IDX_INT_STAT1: next_rdata[1:0] = stat1;
      IDX_EP1_PTR:   next_rdata[2:0] = ep1_bus.ptr;
      IDX_EP1_DATA:  next_rdata[7:0] = ep1_bus.cpu_rdata;
      IDX_EP2_PTR:   next_rdata[2:0] = ep2_bus.ptr;
      IDX_EP2_DATA:  next_rdata[7:0] = ep2_bus.cpu_rdata;
      IDX_EP2_POLL:  next_rdata[7:0] = poll;
      IDX_RXF_DATA:  next_rdata[7:0] = fifo_empty ? DATA_RESET : fifo_mem[rd_ptr];
      IDX_RXF_COUNT: next_rdata[6:0] = rx_count;
      default:       next_rdata = 32'h0000_0000;
    endcase
  end

  // Read data is held from the ack until the next read
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      wb_dat_o <= 32'h0000_0000;
    else if (rd)
      wb_dat_o <= next_rdata;
  end

  // ----------------------------------------------------------------
  // Interrupt enables
  // ----------------------------------------------------------------
  // Enable registers steer the interrupt output
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      en0 <= 3'h0;
      en1 <= 2'h0;
    end
    else if (wr)
    begin
      if (word == IDX_INT_EN0)
        en0 <= wb_dat_i[3:1];
      if (word == IDX_INT_EN1)
        en1 <= wb_dat_i[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Event status
  // ----------------------------------------------------------------
  // Hardware events, the set wins over a clear in the same cycle
  assign set0[ST0_EP1] = usb_ep1_done;
  assign set0[ST0_EP2] = usb_ep2_done;
  assign set0[ST0_EP3] = usb_ep3_done;
  assign set1[ST1_RX_AF] = rx_push && (rx_count == rx_threshold);
  assign set1[ST1_TX_AE] = tx_byte_sent && (tx_count == tx_threshold);

  // Write one to clear
  assign clr0 = (wr && word == IDX_INT_STAT0) ? wb_dat_i[3:1] : 3'h0;
  assign clr1 = (wr && word == IDX_INT_STAT1) ? wb_dat_i[1:0] : 2'h0;

  // Lower status flags
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      stat0 <= 3'h0;
    else
      stat0 <= (stat0 & ~clr0) | set0;
  end

  // Upper status flags
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      stat1 <= 2'h0;
    else
      stat1 <= (stat1 & ~clr1) | set1;
  end

  // Level interrupt while any enabled flag stands
  assign irq = |(stat0 & en0) || |(stat1 & en1);

  // ----------------------------------------------------------------
  // Endpoint 1 receive mailbox
  // ----------------------------------------------------------------
  // CPU only reads, USB only writes
  assign ep1_bus.cpu_access = rd && hit_ep1_data;
  assign ep1_bus.cpu_we     = 1'b0;
  assign ep1_bus.cpu_wdata  = DATA_RESET;
  assign ep1_bus.ptr_we     = 1'b0;
  assign ep1_bus.ptr_wdata  = PTR_RESET;
  assign ep1_bus.usb_we     = usb_ep1_we;
  assign ep1_bus.usb_idx    = usb_ep1_idx;
  assign ep1_bus.usb_wdata  = usb_ep1_data;

  mailbox8 ep1_mbox
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .bus     (ep1_bus.store)
  );

  // ----------------------------------------------------------------
  // Endpoint 2 transmit mailbox
  // ----------------------------------------------------------------
  // CPU reads and writes, USB only reads
  assign ep2_bus.cpu_access = (rd || wr) && hit_ep2_data;
  assign ep2_bus.cpu_we     = wr;
  assign ep2_bus.cpu_wdata  = wb_dat_i[7:0];
  assign ep2_bus.ptr_we     = wr && (word == IDX_EP2_PTR);
  assign ep2_bus.ptr_wdata  = wb_dat_i[2:0];
  assign ep2_bus.usb_we     = 1'b0;
  assign ep2_bus.usb_idx    = usb_ep2_idx;
  assign ep2_bus.usb_wdata  = DATA_RESET;

  mailbox8 ep2_mbox
  (
    .clk_sys (clk_sys),
    .rst     (rst),
    .bus     (ep2_bus.store)
  );

  // Byte toward USB, one cycle behind the index
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      usb_ep2_data <= DATA_RESET;
    else
      usb_ep2_data <= ep2_bus.usb_rdata;
  end

  // Polling interval, also driven out on ep2_poll_interval
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      poll <= POLL_RESET;
    else if (wr && word == IDX_EP2_POLL)
      poll <= wb_dat_i[7:0];
  end

  assign ep2_poll_interval = poll;

  // ----------------------------------------------------------------
  // Endpoint 3 receive FIFO
  // ----------------------------------------------------------------
  assign fifo_full  = (rx_count == COUNT_FULL);
  assign fifo_empty = (rx_count == COUNT_RESET);

  // No new bytes while full or while the endpoint 3 done flag stands uncleared
  assign usb_ep3_ready = !fifo_full && !stat0[ST0_EP3];
  assign rx_push       = usb_ep3_valid && usb_ep3_ready;
  assign rx_pop        = rd && hit_rxf_data && !fifo_empty;

  // Storage
  always_ff @(posedge clk_sys)
  begin
    if (rx_push)
      fifo_mem[wr_ptr] <= usb_ep3_data;
  end

  // Pointers wrap naturally at the depth
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr <= 6'h00;
      rd_ptr <= 6'h00;
    end
    else
    begin
      if (rx_push)
        wr_ptr <= 6'(wr_ptr + 6'h01);
      if (rx_pop)
        rd_ptr <= 6'(rd_ptr + 6'h01);
    end
  end

  // Live entry count
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rx_count <= COUNT_RESET;
    else if (rx_push && !rx_pop)
      rx_count <= 7'(rx_count + 7'h01);
    else if (rx_pop && !rx_push)
      rx_count <= 7'(rx_count - 7'h01);
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_rx_af_set: assert property (
    rx_push && rx_count == rx_threshold |=> stat1[ST1_RX_AF])
    else $error("receive almost-full flag not set");

  chk_tx_ae_set: assert property (
    tx_byte_sent && tx_count == tx_threshold |=> stat1[ST1_TX_AE])
    else $error("transmit almost-empty flag not set");

  chk_rx_af_irq: assert property (
    stat1[ST1_RX_AF] && en1[ST1_RX_AF] |-> irq)
    else $error("enabled almost-full flag gave no interrupt");

  chk_ep1_ptr_step: assert property (
    rd && hit_ep1_data |=> ep1_bus.ptr == 3'($past(ep1_bus.ptr) + 3'h1))
    else $error("endpoint 1 pointer did not step");

  chk_ep2_ptr_step: assert property (
    wr && hit_ep2_data |=> ep2_bus.ptr == 3'($past(ep2_bus.ptr) + 3'h1))
    else $error("endpoint 2 pointer did not step on write");

  chk_ep3_refuse: assert property (
    stat0[ST0_EP3] && !rx_pop |=> rx_count == $past(rx_count))
    else $error("endpoint 3 accepted data while flagged");

  chk_summary_read: assert property (
    rd && word == IDX_INT_STAT0 |=> wb_dat_o[ST0_SUMMARY] == |$past(stat1))
    else $error("summary bit mismatch");

  chk_count_bound: assert property (
    rx_count <= COUNT_FULL && !(fifo_full && rx_push))
    else $error("receive count out of range");

  chk_ep1_flag: assert property (
    usb_ep1_done |=> stat0[ST0_EP1])
    else $error("endpoint 1 flag not set");

  chk_ack_pulse: assert property (
    take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle");

  chk_poll_hold: assert property (
    !(wr && word == IDX_EP2_POLL) |=> poll == $past(poll))
    else $error("polling interval changed without write");

endmodule

`default_nettype wire

/* File: verif/usb_host_model.sv */
`default_nettype none

module usb_host_model
(
  // Clock
  input  wire logic                  clk_sys,
  // Endpoint 1 and 2 mailboxes
  output logic                       usb_ep1_we,
  output usb_mbox_pkg::mbox_idx_t    usb_ep1_idx,
  output usb_mbox_pkg::data8_t       usb_ep1_data,
  output logic                       usb_ep1_done,
  output usb_mbox_pkg::mbox_idx_t    usb_ep2_idx,
  input  wire usb_mbox_pkg::data8_t  usb_ep2_data,
  output logic                       usb_ep2_done,
  // Endpoint 3 receive stream
  output logic                       usb_ep3_valid,
  output usb_mbox_pkg::data8_t       usb_ep3_data,
  input  wire logic                  usb_ep3_ready,
  output logic                       usb_ep3_done
);
  timeunit 1ns;
  timeprecision 1ps;
  import usb_mbox_pkg::*;

  logic ready_seen;

  // Ready as the coming rising edge will see it
  always @(negedge clk_sys)
  begin
    ready_seen = usb_ep3_ready;
  end

  // Idle levels at time zero
  initial
  begin
    {usb_ep1_we, usb_ep1_done, usb_ep2_done, usb_ep3_valid, usb_ep3_done} = 5'h00;
    usb_ep1_idx  = 3'h0;
    usb_ep1_data = 8'h00;
    usb_ep2_idx  = 3'h0;
    usb_ep3_data = 8'h00;
  end

  // Host writes one mailbox byte; released data shows the inverse
  task automatic ep1_write(input mbox_idx_t idx, input data8_t d);
    @(posedge clk_sys);
    usb_ep1_we   <= 1'b1;
    usb_ep1_idx  <= idx;
    usb_ep1_data <= d;
    @(posedge clk_sys);
    usb_ep1_we   <= 1'b0;
    usb_ep1_data <= ~d;
  endtask

  // Host fetches one transmit byte, registered one cycle after the index
  task automatic ep2_read(input mbox_idx_t idx, output data8_t d);
    @(posedge clk_sys);
    usb_ep2_idx <= idx;
    @(posedge clk_sys);
    @(negedge clk_sys);
    d = usb_ep2_data;
  endtask

  // One-cycle end-of-transfer pulse on the chosen endpoint
  task automatic end_of_packet(input int ep);
    @(posedge clk_sys);
    usb_ep1_done <= (ep == 1);
    usb_ep2_done <= (ep == 2);
    usb_ep3_done <= (ep == 3);
    @(posedge clk_sys);
    {usb_ep1_done, usb_ep2_done, usb_ep3_done} <= 3'h0;
  endtask

  // Offer a byte for at most limit edges; withdraw if never taken
  task automatic offer(input data8_t d, input int limit, output logic taken);
    int n;
    taken = 1'b0;
    @(posedge clk_sys);
    usb_ep3_valid <= 1'b1;
    usb_ep3_data  <= d;
    for (n = 0; n < limit && !taken; n++)
    begin
      @(posedge clk_sys);
      taken = ready_seen;
    end
    usb_ep3_valid <= 1'b0;
    usb_ep3_data  <= ~d;
  endtask
endmodule

`default_nettype wire

/* File: verif/usb_endpoint_mailbox_fifo_test.sv */
`default_nettype none

module usb_endpoint_mailbox_fifo_test;
  timeunit 1ns;
  timeprecision 1ps;
  import usb_mbox_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic              clk_sys;
  logic              rst;
  logic              wb_cyc;
  logic              wb_stb;
  logic              wb_we;
  logic [ADR_W-1:0]  wb_adr;
  logic [SEL_W-1:0]  wb_sel;
  logic [DAT_W-1:0]  wb_wdat;
  logic [DAT_W-1:0]  wb_rdat;
  logic              wb_ack;
  logic              irq;
  logic              ep1_we;
  mbox_idx_t         ep1_idx;
  data8_t            ep1_data;
  logic              ep1_done;
  mbox_idx_t         ep2_idx;
  data8_t            ep2_data;
  logic              ep2_done;
  data8_t            poll;
  logic              ep3_valid;
  data8_t            ep3_data;
  logic              ep3_ready;
  logic              ep3_done;
  fifo_count_t       tx_count;
  logic              tx_byte_sent;
  fifo_count_t       tx_threshold;
  fifo_count_t       rx_threshold;
  int                bad_count = 0;
  int                checked   = 0;
  int                cycles    = 0;

  usb_endpoint_mailbox_fifo u_dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq(irq),
    .usb_ep1_we(ep1_we), .usb_ep1_idx(ep1_idx), .usb_ep1_data(ep1_data),
    .usb_ep1_done(ep1_done), .usb_ep2_idx(ep2_idx), .usb_ep2_data(ep2_data),
    .usb_ep2_done(ep2_done), .ep2_poll_interval(poll), .usb_ep3_valid(ep3_valid),
    .usb_ep3_data(ep3_data), .usb_ep3_ready(ep3_ready), .usb_ep3_done(ep3_done),
    .tx_count(tx_count), .tx_byte_sent(tx_byte_sent), .tx_threshold(tx_threshold),
    .rx_threshold(rx_threshold));

  usb_host_model u_host (.clk_sys(clk_sys), .usb_ep1_we(ep1_we), .usb_ep1_idx(ep1_idx),
    .usb_ep1_data(ep1_data), .usb_ep1_done(ep1_done), .usb_ep2_idx(ep2_idx),
    .usb_ep2_data(ep2_data), .usb_ep2_done(ep2_done), .usb_ep3_valid(ep3_valid),
    .usb_ep3_data(ep3_data), .usb_ep3_ready(ep3_ready), .usb_ep3_done(ep3_done));

  // ----------------------------------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------------------------------
  always #25 clk_sys = ~clk_sys;

  // Cuts a hang short
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checked %0d, bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // One classic cycle; ack and read data taken at the same rising edge
  task automatic wb_xfer(input logic [15:0] idx, input logic we, input data8_t wd,
                         output logic [31:0] rd);
    @(posedge clk_sys);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= {idx, 2'b00};
    wb_wdat <= {24'h0, wd};
    do
    begin
      @(posedge clk_sys);
    end while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] idx, input data8_t d);
    logic [31:0] dummy;
    wb_xfer(idx, 1'b1, d, dummy);
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp, input string what);
    logic [31:0] v;
    wb_xfer(idx, 1'b0, 8'h00, v);
    check(v, exp, what);
  endtask

  // Transmit progress pulse with a given live count
  task automatic tx_sent(input fifo_count_t cnt);
    @(posedge clk_sys);
    tx_count     <= cnt;
    tx_byte_sent <= 1'b1;
    @(posedge clk_sys);
    tx_byte_sent <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset();
    check(poll, POLL_RESET, "poll port reset");
    rd_chk(IDX_EP2_POLL, 32'hff, "poll reset");
    rd_chk(IDX_EP1_DATA, 32'h0, "ep1 data reset");
    rd_chk(IDX_RXF_COUNT, 32'h0, "count reset");
    wr(IDX_EP1_PTR, 8'h05);
    rd_chk(IDX_EP1_PTR, 32'h1, "ep1 ptr not writable");
    rd_chk(16'h4030, 32'h0, "unmapped read");
    wr(IDX_EP2_POLL, 8'h0a);
    rd_chk(IDX_EP2_POLL, 32'h0a, "poll rw");
    check(poll, 8'h0a, "poll port");
  endtask

  task automatic test_ep1();
    int i;
    wr(IDX_INT_EN0, 8'h02);
    for (i = 0; i < 8; i++)
      u_host.ep1_write(3'(i), 8'h30 + 8'(i));
    u_host.end_of_packet(1);
    rd_chk(IDX_INT_STAT0, 32'h02, "ep1 status");
    check(irq, 1'b1, "ep1 irq");
    for (i = 1; i < 10; i++)
      rd_chk(IDX_EP1_DATA, 32'h30 + (i % 8), "ep1 byte");
    rd_chk(IDX_EP1_PTR, 32'h2, "ep1 ptr wrap");
    wr(IDX_INT_EN0, 8'h00);
    check(irq, 1'b0, "ep1 masked");
    wr(IDX_INT_STAT0, 8'h02);
    rd_chk(IDX_INT_STAT0, 32'h0, "ep1 cleared");
  endtask

  task automatic test_ep2();
    data8_t v;
    wr(IDX_EP2_PTR, 8'h06);
    wr(IDX_EP2_DATA, 8'h66);
    wr(IDX_EP2_DATA, 8'h77);
    wr(IDX_EP2_DATA, 8'h80);
    rd_chk(IDX_EP2_PTR, 32'h1, "ep2 ptr wrap");
    u_host.ep2_read(3'h7, v);
    check(v, 8'h77, "ep2 host byte 7");
    u_host.ep2_read(3'h0, v);
    check(v, 8'h80, "ep2 host byte 0");
    wr(IDX_EP2_PTR, 8'h06);
    rd_chk(IDX_EP2_DATA, 32'h66, "ep2 cpu read");
    rd_chk(IDX_EP2_PTR, 32'h7, "ep2 ptr after read");
    wr(IDX_INT_EN0, 8'h04);
    u_host.end_of_packet(2);
    rd_chk(IDX_INT_STAT0, 32'h04, "ep2 status");
    check(irq, 1'b1, "ep2 irq");
    wr(IDX_INT_STAT0, 8'h04);
    wr(IDX_INT_EN0, 8'h00);
  endtask

  task automatic test_rx_fifo();
    logic ok;
    int   i;
    @(posedge clk_sys);
    rx_threshold <= 7'd2;
    wr(IDX_INT_EN1, 8'h01);
    u_host.offer(8'ha0, 8, ok);
    u_host.offer(8'ha1, 8, ok);
    rd_chk(IDX_INT_STAT1, 32'h0, "rx af early");
    check(irq, 1'b0, "rx af irq early");
    u_host.offer(8'ha2, 8, ok);
    rd_chk(IDX_INT_STAT1, 32'h1, "rx af set");
    check(irq, 1'b1, "rx af irq");
    u_host.end_of_packet(3);
    rd_chk(IDX_INT_STAT0, 32'h09, "ep3 and summary");
    check(ep3_ready, 1'b0, "ep3 blocked");
    u_host.offer(8'hee, 4, ok);
    check(ok, 1'b0, "ep3 refused");
    rd_chk(IDX_RXF_COUNT, 32'h3, "count 3");
    wr(IDX_INT_STAT0, 8'h08);
    wr(IDX_INT_STAT1, 8'h01);
    rd_chk(IDX_INT_STAT0, 32'h0, "summary clear");
    check(irq, 1'b0, "rx af irq clear");
    for (i = 0; i < 3; i++)
      rd_chk(IDX_RXF_DATA, 32'ha0 + i, "fifo pop");
    rd_chk(IDX_RXF_COUNT, 32'h0, "count empty");
    rd_chk(IDX_RXF_DATA, 32'h0, "empty pop");
    for (i = 0; i < 64; i++)
      u_host.offer(8'(i), 8, ok);
    rd_chk(IDX_RXF_COUNT, 32'h40, "count full");
    u_host.offer(8'hee, 4, ok);
    check(ok, 1'b0, "full refused");
    rd_chk(IDX_RXF_DATA, 32'h0, "first of full");
    wr(IDX_INT_STAT1, 8'h01);
    wr(IDX_INT_EN1, 8'h00);
  endtask

  task automatic test_tx_event();
    @(posedge clk_sys);
    tx_threshold <= 7'd3;
    tx_sent(7'd4);
    rd_chk(IDX_INT_STAT1, 32'h0, "tx ae early");
    wr(IDX_INT_EN1, 8'h02);
    tx_sent(7'd3);
    rd_chk(IDX_INT_STAT1, 32'h2, "tx ae set");
    rd_chk(IDX_INT_STAT0, 32'h1, "tx summary");
    check(irq, 1'b1, "tx ae irq");
    wr(IDX_INT_STAT1, 8'h02);
    rd_chk(IDX_INT_STAT1, 32'h0, "tx ae clear");
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    clk_sys      = 1'b0;
    rst          = 1'b1;
    {wb_cyc, wb_stb, wb_we, tx_byte_sent} = 4'h0;
    wb_adr       = '0;
    wb_sel       = 4'h1;
    wb_wdat      = 32'h0;
    tx_count     = 7'h00;
    tx_threshold = 7'd1;
    rx_threshold = 7'd63;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    test_reset();
    test_ep1();
    test_ep2();
    test_rx_fifo();
    test_tx_event();
    print_verdict();
  end
endmodule

`default_nettype wire
